// ---- inc/rse_pkg.sv ----
// Constants and types for the remote status and error queue block
package rse_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_CMD    = 5'h04;
  localparam logic [4:0] ADDR_ENABLE = 5'h08;
  localparam logic [4:0] ADDR_EVENT  = 5'h0c;
  localparam logic [4:0] ADDR_STB    = 5'h10;
  localparam logic [4:0] ADDR_ERROR  = 5'h14;
  localparam logic [4:0] ADDR_OPCQ   = 5'h18;
  localparam logic [4:0] ADDR_COUNT  = 5'h1c;

  // Field positions
  localparam int CTRL_ALARM_BIT = 0;
  localparam int CMD_CLS_BIT    = 0;
  localparam int CMD_OPC_BIT    = 1;
  localparam int EV_OPC_BIT     = 0;
  localparam int EV_DEV_BIT     = 3;
  localparam int EV_EXE_BIT     = 4;
  localparam int EV_CMD_BIT     = 5;
  localparam int STB_ERRQ_BIT   = 2;
  localparam int STB_ESB_BIT    = 5;

  // Reset values
  localparam logic [7:0] EVENT_RST  = 8'h80;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic       ALARM_RST  = 1'b1;

  localparam int QUEUE_DEPTH = 20;
  localparam int MSG_MAX     = 255;
  localparam logic [31:0] OPC_REPLY = 32'h0000_0001;

  typedef enum logic [4:0] {
    EK_INV_CHAR, EK_SYNTAX, EK_SEPARATOR, EK_PARAM_EXTRA, EK_PARAM_MISSING,
    EK_HDR_LONG, EK_HDR_UNDEF, EK_EXP_LARGE, EK_NUM_TYPE, EK_SUFFIX_BAD,
    EK_SUFFIX_NA, EK_CHAR_TYPE, EK_STR_TYPE, EK_EXPR, EK_CONFLICT,
    EK_RANGE, EK_OVERFLOW
  } err_kind_t;

  typedef enum logic [1:0] {CLS_COMMAND, CLS_EXECUTION, CLS_DEVICE} err_class_t;

  // One fault report from the command parser / executor
  typedef struct packed {
    logic      valid;
    err_kind_t kind;
  } err_report_t;

  // Decoded queue entry as software sees it
  typedef struct packed {
    logic [7:0]  text_len;
    logic [15:0] code;
  } err_entry_t;

endpackage

// ---- rtl/remote_status_error_queue.sv ----
// Status registers, clear/OPC commands and error queue of the remote port
//
// Behaviour
// - Enable register stores 0..255 and reads back the same value.
// - Event status read returns the 8-bit weighted sum of set bits.
// - Clear-status zeroes status byte and all event registers together.
// - OPC command sets event bit 0 only once earlier commands finish.
// - OPC query answers 1 after earlier commands finish; events untouched.
// - Error queue is first-in first-out; a read gives the oldest entry.
// - Reading an error entry removes it from the queue.
// - Past 20 errors newest slot becomes -350; further errors dropped.
// - Clear-status and power-down empty queue; reset command does not.
// - Each error read gives one code and text of at most 255 characters.
// - Alarm trigger pulses once per error entered, enabled by default.
// - Codes -101 invalid char, -102 syntax, -103 separator.
// - Code -108 too many parameters, -109 too few.
// - Code -112 when a header exceeds 12 characters.
// - Code -113 for undefined header, including long short forms.
// - Code -123 when an exponent exceeds 32,000.
// - Wrong type: -128 numeric, -148 character, -158 string data.
// - Code -131 bad suffix, -138 suffix not allowed.
// - Code -170 for an expression where none is accepted.
// - Code -221 for a legal command impossible in current state.
// - Code -222 for a parameter value out of range.
// - Status byte bit 2 is set while the error queue holds entries.
// - Command errors set event weight 32, execution errors weight 16.
// - Summary bit set when any event bit and its enable are both set.
// - Event status register is cleared after it is read.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module remote_status_error_queue
  import rse_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input  wire logic        I_CLK,         // 100 MHz system clock
  input  wire logic        I_SYS_RST,     // Async reset, active high
  input  wire logic [4:0]  I_ADDRESS,     // Avalon byte address
  input  wire logic        I_READ,        // Avalon read request
  input  wire logic        I_WRITE,       // Avalon write request
  input  wire logic [31:0] I_WRITEDATA,   // Avalon write data
  input  wire logic [3:0]  I_BYTEENABLE,  // Avalon byte lanes
  output logic      [31:0] O_READDATA,    // Avalon read data
  output logic             O_WAITREQUEST, // Avalon stall
  input  wire err_report_t I_ERR,         // Fault report from parser
  input  wire logic        I_BUSY,        // Earlier commands still running
  output logic             O_ALARM,       // One-cycle alarm tone trigger
  output logic [7:0]       O_STATUS_BYTE  // Live status byte
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [PW-1:0] ptr_dec(input logic [PW-1:0] p);
    ptr_dec = (p == '0) ? LAST_IDX : p - 1'b1;
  endfunction

  // Kind to numeric code, two's complement
  function automatic logic [15:0] err_code(input err_kind_t k);
    case (k)
      EK_INV_CHAR:      err_code = -16'sd101;
      EK_SYNTAX:        err_code = -16'sd102;
      EK_SEPARATOR:     err_code = -16'sd103;
      EK_PARAM_EXTRA:   err_code = -16'sd108;
      EK_PARAM_MISSING: err_code = -16'sd109;
      EK_HDR_LONG:      err_code = -16'sd112;
      EK_HDR_UNDEF:     err_code = -16'sd113;
      EK_EXP_LARGE:     err_code = -16'sd123;
      EK_NUM_TYPE:      err_code = -16'sd128;
      EK_SUFFIX_BAD:    err_code = -16'sd131;
      EK_SUFFIX_NA:     err_code = -16'sd138;
      EK_CHAR_TYPE:     err_code = -16'sd148;
      EK_STR_TYPE:      err_code = -16'sd158;
      EK_EXPR:          err_code = -16'sd170;
      EK_CONFLICT:      err_code = -16'sd221;
      EK_RANGE:         err_code = -16'sd222;
      EK_OVERFLOW:      err_code = -16'sd350;
      default:          err_code = '0;
    endcase
  endfunction

  // Text length per kind; all stay far below MSG_MAX
  function automatic logic [7:0] msg_len(input err_kind_t k);
    case (k)
      EK_INV_CHAR:      msg_len = 8'd17;
      EK_SYNTAX:        msg_len = 8'd12;
      EK_SEPARATOR:     msg_len = 8'd17;
      EK_PARAM_EXTRA:   msg_len = 8'd21;
      EK_PARAM_MISSING: msg_len = 8'd17;
      EK_HDR_LONG:      msg_len = 8'd25;
      EK_HDR_UNDEF:     msg_len = 8'd16;
      EK_EXP_LARGE:     msg_len = 8'd18;
      EK_NUM_TYPE:      msg_len = 8'd24;
      EK_SUFFIX_BAD:    msg_len = 8'd14;
      EK_SUFFIX_NA:     msg_len = 8'd18;
      EK_CHAR_TYPE:     msg_len = 8'd26;
      EK_STR_TYPE:      msg_len = 8'd23;
      EK_EXPR:          msg_len = 8'd16;
      EK_CONFLICT:      msg_len = 8'd16;
      EK_RANGE:         msg_len = 8'd17;
      EK_OVERFLOW:      msg_len = 8'd14;
      default:          msg_len = '0;
    endcase
  endfunction

  function automatic err_entry_t decode(input err_kind_t k);
    decode = '{msg_len(k), err_code(k)};
  endfunction

  function automatic err_class_t classify(input err_kind_t k);
    case (k)
      EK_CONFLICT, EK_RANGE: classify = CLS_EXECUTION;
      EK_OVERFLOW:           classify = CLS_DEVICE;
      default:               classify = CLS_COMMAND;
    endcase
  endfunction

  // Bus handshake: one wait state, more for a completion query while busy, so read data comes from a flop
  logic        ack;
  logic        req;
  logic        fire;
  logic        stall;
  logic [31:0] captured;
  logic        pop_ok;

  assign req   = I_READ | I_WRITE;
  assign stall = I_READ & (I_ADDRESS == ADDR_OPCQ) & I_BUSY;
  assign fire  = req & ack;
  assign O_WAITREQUEST = req & ~ack;

  logic wr_ctrl;
  logic wr_cmd;
  logic wr_enable;
  logic rd_event;
  logic rd_error;
  logic do_cls;
  logic do_opc;

  assign wr_ctrl   = fire & I_WRITE & (I_ADDRESS == ADDR_CTRL) & I_BYTEENABLE[0];
  assign wr_cmd    = fire & I_WRITE & (I_ADDRESS == ADDR_CMD) & I_BYTEENABLE[0];
  assign wr_enable = fire & I_WRITE & (I_ADDRESS == ADDR_ENABLE)
                     & I_BYTEENABLE[0];
  assign rd_event  = fire & I_READ & (I_ADDRESS == ADDR_EVENT);
  assign rd_error  = fire & I_READ & (I_ADDRESS == ADDR_ERROR) & pop_ok;
  assign do_cls    = wr_cmd & I_WRITEDATA[CMD_CLS_BIT];
  assign do_opc    = wr_cmd & I_WRITEDATA[CMD_OPC_BIT];

  // Registers
  logic [7:0] std_event_enable_reg;
  logic [7:0] std_event_status_reg;
  logic       alarm_en;
  logic       opc_pending;

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      alarm_en <= ALARM_RST;
    end else if (wr_ctrl) begin
      alarm_en <= I_WRITEDATA[CTRL_ALARM_BIT];
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      std_event_enable_reg <= ENABLE_RST;
    end else if (wr_enable) begin
      std_event_enable_reg <= I_WRITEDATA[7:0];
    end
  end

  // Held until the executor reports idle, so it trails earlier commands
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      opc_pending <= 1'b0;
    end else if (do_opc) begin
      opc_pending <= 1'b1;
    end else if (opc_pending & ~I_BUSY) begin
      opc_pending <= 1'b0;
    end
  end

  // Queue storage and pointers
  err_kind_t       slots [DEPTH];
  logic [PW-1:0]   rd_ptr;
  logic [PW-1:0]   wr_ptr;
  logic [CW-1:0]   count;
  logic            locked;
  logic            push;
  logic            replace;
  logic            entered;

  // A pop in the same cycle frees room for the new entry
  assign push    = I_ERR.valid & ~locked & ~do_cls
                   & ((count != FULL_CNT) | rd_error);
  assign replace = I_ERR.valid & ~locked & ~do_cls
                   & (count == FULL_CNT) & ~rd_error;
  assign entered = push | replace;

  // Events raised this cycle
  logic [7:0] ev_set;
  err_class_t cls_now;

  always_comb begin
    ev_set  = '0;
    cls_now = classify(I_ERR.kind);
    if (opc_pending & ~I_BUSY) begin
      ev_set[EV_OPC_BIT] = 1'b1;
    end
    if (entered) begin
      case (replace ? CLS_DEVICE : cls_now)
        CLS_EXECUTION: ev_set[EV_EXE_BIT] = 1'b1;
        CLS_DEVICE:    ev_set[EV_DEV_BIT] = 1'b1;
        default:       ev_set[EV_CMD_BIT] = 1'b1;
      endcase
    end
  end

  // Set wins over clear; a read clears only the bits it reported
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      std_event_status_reg <= EVENT_RST;
    end else if (do_cls) begin
      std_event_status_reg <= ev_set;
    end else if (rd_event) begin
      std_event_status_reg <= (std_event_status_reg & ~captured[7:0])
                              | ev_set;
    end else begin
      std_event_status_reg <= std_event_status_reg | ev_set;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (push) begin
      slots[wr_ptr] <= I_ERR.kind;
    end else if (replace) begin
      slots[ptr_dec(wr_ptr)] <= EK_OVERFLOW;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_ptr <= '0;
    end else if (do_cls) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= ptr_inc(wr_ptr);
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rd_ptr <= '0;
    end else if (do_cls) begin
      rd_ptr <= '0;
    end else if (rd_error) begin
      rd_ptr <= ptr_inc(rd_ptr);
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      count <= '0;
    end else if (do_cls) begin
      count <= '0;
    end else begin
      case ({push, rd_error})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

  // Lock lifts once the queue is cleared or read empty
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      locked <= 1'b0;
    end else if (do_cls) begin
      locked <= 1'b0;
    end else if (replace) begin
      locked <= 1'b1;
    end else if (rd_error & (count == CW'(1)) & ~push) begin
      locked <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_ALARM <= 1'b0;
    end else begin
      O_ALARM <= entered & alarm_en;
    end
  end

  // Status byte, derived so a clear of its sources clears it too
  logic [7:0] status_byte;

  always_comb begin
    status_byte               = '0;
    status_byte[STB_ERRQ_BIT] = (count != '0);
    status_byte[STB_ESB_BIT]  = |(std_event_status_reg
                                  & std_event_enable_reg);
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_STATUS_BYTE <= '0;
    end else if (do_cls) begin
      O_STATUS_BYTE <= '0;
    end else begin
      O_STATUS_BYTE <= status_byte;
    end
  end

  // Read mux sampled in the wait state
  err_entry_t head;
  logic [31:0] rd_mux;

  always_comb begin
    head   = decode(slots[rd_ptr]);
    rd_mux = '0;
    case (I_ADDRESS)
      ADDR_CTRL:   rd_mux[CTRL_ALARM_BIT] = alarm_en;
      ADDR_ENABLE: rd_mux[7:0] = std_event_enable_reg;
      ADDR_EVENT:  rd_mux[7:0] = std_event_status_reg;
      ADDR_STB:    rd_mux[7:0] = status_byte;
      ADDR_ERROR:  rd_mux = (count != '0) ? {8'h00, head} : '0;
      ADDR_OPCQ:   rd_mux = OPC_REPLY;
      ADDR_COUNT:  rd_mux[CW-1:0] = count;
      default:     rd_mux = '0;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack & ~stall;
    end
  end

  // Refreshed every wait cycle, so a stalled query returns fresh data
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      captured <= '0;
    end else if (req & ~ack) begin
      captured <= rd_mux;
    end
  end

  // An empty-queue read must not move the read pointer
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pop_ok <= 1'b0;
    end else if (req & ~ack) begin
      pop_ok <= (count != '0);
    end
  end

  assign O_READDATA = captured;

endmodule

// ---- tb/remote_status_error_queue_checker.sv ----
// Port assertions for the status and error queue block
`timescale 1ns/1ps
module remote_status_error_queue_checker
  import rse_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic        I_CLK,         // Clock
  input wire logic        I_SYS_RST,     // Reset
  input wire logic [4:0]  I_ADDRESS,     // Address
  input wire logic        I_READ,        // Read
  input wire logic        I_WRITE,       // Write
  input wire logic [31:0] I_WRITEDATA,   // Write data
  input wire logic [3:0]  I_BYTEENABLE,  // Lanes
  input wire logic [31:0] O_READDATA,    // Read data
  input wire logic        O_WAITREQUEST, // Stall
  input wire err_report_t I_ERR,         // Fault report
  input wire logic        I_BUSY,        // Busy
  input wire logic        O_ALARM,       // Alarm
  input wire logic [7:0]  O_STATUS_BYTE  // Status byte
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  wire done = (I_READ || I_WRITE) && !O_WAITREQUEST;
  wait_start_a: assert property ($rose(I_READ || I_WRITE) |-> O_WAITREQUEST)
    else $error("request answered without wait state");
  one_wait_a: assert property ((O_WAITREQUEST && (I_WRITE || (I_READ &&
    I_ADDRESS != ADDR_OPCQ))) |=> !O_WAITREQUEST)
    else $error("plain access not answered after one wait");
  opc_stall_a: assert property ((I_READ && I_ADDRESS == ADDR_OPCQ &&
    I_BUSY && $past(I_BUSY)) |-> O_WAITREQUEST)
    else $error("completion query answered while busy");
  opc_reply_a: assert property ((done && I_READ && I_ADDRESS == ADDR_OPCQ)
    |-> O_READDATA == OPC_REPLY)
    else $error("completion query reply wrong");
  alarm_cause_a: assert property (O_ALARM |-> $past(I_ERR.valid))
    else $error("alarm without fault report");
  errq_flag_a: assert property (O_ALARM |=> O_STATUS_BYTE[STB_ERRQ_BIT])
    else $error("queue flag missing after entry");
  cls_zero_a: assert property ((done && I_WRITE && I_ADDRESS == ADDR_CMD &&
    I_WRITEDATA[CMD_CLS_BIT] && I_BYTEENABLE[0] && !I_ERR.valid)
    |=> ##1 O_STATUS_BYTE == 8'h00)
    else $error("status byte not cleared");
  stb_unused_a: assert property ({O_STATUS_BYTE[7:6], O_STATUS_BYTE[4:3],
    O_STATUS_BYTE[1:0]} == 6'h00)
    else $error("unused status bits set");
  entry_form_a: assert property ((done && I_READ && I_ADDRESS == ADDR_ERROR)
    |-> O_READDATA[31:24] == 8'h00)
    else $error("error entry upper byte set");
endmodule
bind remote_status_error_queue remote_status_error_queue_checker #(
  .DEPTH(DEPTH)) u_chk (.*);

// ---- tb/remote_status_error_queue_tb.sv ----
// Register level tests of the status and error queue block
`timescale 1ns/1ps
module remote_status_error_queue_tb
  import rse_pkg::*;
;
  logic clk, rst, rd, wr, wreq, alarm;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [7:0] stb;
  err_report_t err;
  logic busy;
  logic [3:0] be, lanes;
  int mismatches, checks, alarms, n;
  // Codes in kind order; overflow last
  int codes[17] = '{-101, -102, -103, -108, -109, -112, -113, -123, -128,
    -131, -138, -148, -158, -170, -221, -222, -350};
  remote_status_error_queue #(.DEPTH(4)) u_dut (.I_CLK(clk),
    .I_SYS_RST(rst), .I_ADDRESS(addr), .I_READ(rd), .I_WRITE(wr),
    .I_WRITEDATA(wdata), .I_BYTEENABLE(be), .O_READDATA(rdata),
    .O_WAITREQUEST(wreq), .I_ERR(err), .I_BUSY(busy), .O_ALARM(alarm),
    .O_STATUS_BYTE(stb));
  rse_host_model u_host (.i_clk(clk), .o_err(err), .o_busy(busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (alarm === 1'b1) alarms++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [4:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    be <= lanes;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 500);
    if (n >= 500) begin
      chk(32'h1, 32'h0);
      stop_test();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic pop(input int k);
    bus(ADDR_ERROR, 1'b0, 32'h0);
    chk({16'h0, q[15:0]}, {16'h0, 16'(codes[k])});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'hf;
    lanes = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_CTRL, 32'h1);
    rchk(ADDR_ENABLE, 32'h0);
    rchk(ADDR_EVENT, 32'h80);
    rchk(ADDR_EVENT, 32'h0);
    $display("test reset done");
    foreach (codes[i]) if (i < 3) begin
      bus(ADDR_ENABLE, 1'b1, i == 0 ? 32'd65 : i == 1 ? 32'd255 : 32'd0);
      rchk(ADDR_ENABLE, i == 0 ? 32'd65 : i == 1 ? 32'd255 : 32'd0);
    end
    // Lane 0 off: the write must be ignored
    lanes = 4'he;
    bus(ADDR_ENABLE, 1'b1, 32'h55);
    lanes = 4'hf;
    rchk(ADDR_ENABLE, 32'h0);
    $display("test enable done");
    for (int k = 0; k < 16; k++) begin
      u_host.push(k);
      pop(k);
      rchk(ADDR_EVENT, k < 14 ? 32'h20 : 32'h10);
    end
    chk(alarms, 16);
    bus(ADDR_CTRL, 1'b1, 32'h0);
    u_host.push(2);
    repeat (3) @(posedge clk);
    chk(alarms, 16);
    pop(2);
    bus(ADDR_CTRL, 1'b1, 32'h1);
    rchk(ADDR_EVENT, 32'h20);
    $display("test codes done");
    for (int k = 0; k < 6; k++) u_host.push(k);
    rchk(ADDR_COUNT, 32'h4);
    chk(stb[STB_ERRQ_BIT], 1'b1);
    rchk(ADDR_EVENT, 32'h28);
    for (int k = 0; k < 3; k++) pop(k);
    pop(16);
    rchk(ADDR_ERROR, 32'h0);
    repeat (2) @(posedge clk);
    chk(stb[STB_ERRQ_BIT], 1'b0);
    u_host.push(5);
    pop(5);
    $display("test overflow done");
    bus(ADDR_ENABLE, 1'b1, 32'h20);
    u_host.push(0);
    u_host.push(15);
    repeat (2) @(posedge clk);
    chk(stb, 8'h24);
    rchk(ADDR_STB, 32'h24);
    bus(ADDR_CMD, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk(stb, 8'h00);
    rchk(ADDR_COUNT, 32'h0);
    rchk(ADDR_EVENT, 32'h0);
    rchk(ADDR_ERROR, 32'h0);
    $display("test clear done");
    u_host.busy(1'b1);
    bus(ADDR_CMD, 1'b1, 32'h2);
    repeat (5) @(posedge clk);
    rchk(ADDR_EVENT, 32'h0);
    u_host.busy(1'b0);
    repeat (2) @(posedge clk);
    rchk(ADDR_EVENT, 32'h1);
    u_host.busy(1'b1);
    fork
      rchk(ADDR_OPCQ, OPC_REPLY);
      begin
        repeat (8) @(posedge clk);
        u_host.busy(1'b0);
      end
    join
    chk(n > 8, 1'b1);
    rchk(ADDR_EVENT, 32'h0);
    $display("test completion done");
    // Power-down in mid-run empties the queue, restores power-on event
    u_host.push(3);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_COUNT, 32'h0);
    rchk(ADDR_EVENT, 32'h80);
    rchk(ADDR_ERROR, 32'h0);
    $display("test power-down done");
    stop_test();
  end
endmodule

// ---- tb/rse_host_model.sv ----
// Fault reporter and busy line standing in for the command parser
`timescale 1ns/1ps
module rse_host_model
  import rse_pkg::*;
(
  input  wire logic  i_clk,  // System clock
  output err_report_t o_err, // One-cycle fault report
  output logic        o_busy // Earlier commands running
);
  initial begin
    o_err  = '0;
    o_busy = 1'b0;
  end
  task automatic push(input int k);
    @(posedge i_clk);
    o_err <= {1'b1, err_kind_t'(k)};
    @(posedge i_clk);
    o_err <= '0;
  endtask
  task automatic busy(input logic b);
    @(posedge i_clk);
    o_busy <= b;
  endtask
endmodule
